//--- core/mcd_pkg.sv
package mcd_pkg;
	// register byte addresses, one aligned word each
	localparam logic [7:0]  MCD_ADDR_SIZE     = 8'h00;
	localparam logic [7:0]  MCD_ADDR_PLIMIT   = 8'h04;
	localparam logic [7:0]  MCD_ADDR_URGENT   = 8'h08;
	localparam logic [7:0]  MCD_ADDR_FEAT_OFF = 8'h10;
	localparam logic [7:0]  MCD_ADDR_FEAT_ACK = 8'h14;
	localparam logic [7:0]  MCD_ADDR_MODE     = 8'h18;
	localparam logic [7:0]  MCD_ADDR_STATUS   = 8'h1C;
	localparam logic [7:0]  MCD_ADDR_HPORT    = 8'h20;
	localparam logic [7:0]  MCD_ADDR_HCMD     = 8'h24;
	localparam logic [7:0]  MCD_ADDR_NEWSIZE  = 8'h28;
	localparam logic [7:0]  MCD_ADDR_NAME     = 8'h2C;
	localparam logic [7:0]  MCD_ADDR_EXIST    = 8'h30;
	localparam logic [7:0]  MCD_ADDR_PREADY   = 8'h34;
	localparam logic [7:0]  MCD_ADDR_GOPEN    = 8'h38;
	// feature bit positions and the offered set
	localparam int          MCD_F_SIZE        = 0;
	localparam int          MCD_F_MULTI       = 1;
	localparam int          MCD_F_EMERG       = 2;
	localparam logic [2:0]  MCD_FEAT_OFFERED  = 3'h7;
	// control event codes
	localparam logic [15:0] MCD_EV_DRV_READY  = 16'h0000;
	localparam logic [15:0] MCD_EV_PORT_ADD   = 16'h0001;
	localparam logic [15:0] MCD_EV_PORT_DEL   = 16'h0002;
	localparam logic [15:0] MCD_EV_PORT_READY = 16'h0003;
	localparam logic [15:0] MCD_EV_CONSOLE    = 16'h0004;
	localparam logic [15:0] MCD_EV_RESIZE     = 16'h0005;
	localparam logic [15:0] MCD_EV_PORT_OPEN  = 16'h0006;
	localparam logic [15:0] MCD_EV_PORT_NAME  = 16'h0007;
	localparam logic [15:0] MCD_VAL_ONE       = 16'h0001;
	// queue indices
	localparam logic [7:0]  MCD_Q_P0_RX       = 8'h00;
	localparam logic [7:0]  MCD_Q_P0_TX       = 8'h01;
	localparam logic [7:0]  MCD_Q_CTRL_RX     = 8'h02;
	localparam logic [7:0]  MCD_Q_CTRL_TX     = 8'h03;
	localparam logic [7:0]  MCD_Q_P1_RX       = 8'h04;
	// mode, status and command field positions
	localparam int          MCD_MODE_LEGACY   = 0;
	localparam int          MCD_MODE_GBE      = 1;
	localparam int          MCD_ST_DRV_READY  = 0;
	localparam int          MCD_ST_BUSY       = 1;
	localparam int          MCD_ST_REFUSED    = 2;
	localparam int          MCD_ST_DRV_FAIL   = 3;
	localparam int          MCD_CMD_EV_LSB    = 0;
	localparam int          MCD_CMD_NLEN_LSB  = 4;
	localparam int          MCD_CMD_VAL_LSB   = 16;
	// reset values
	localparam logic [15:0] MCD_COLS_RST      = 16'h0050;
	localparam logic [15:0] MCD_ROWS_RST      = 16'h0019;
	localparam logic [2:0]  MCD_FEAT_ACK_RST  = 3'h0;
	localparam logic [1:0]  MCD_MODE_RST      = 2'h0;
endpackage

//--- core/mcd_console_core.sv
`timescale 1ns/10ps
// Function
// - queue 0/1 port0 pair, 2/3 control, port n at 2n+2; others need multiport.
// - offer feature bits 0 size, 1 multiport, 2 emergency write.
// - config holds cols16, rows16, port limit 32, emergency word 32, little-endian.
// - legacy mode uses guest native order for config and control fields.
// - emergency write accepted any time, even before setup or feature ack.
// - low byte of each emergency write goes out as one character.
// - size change raises config-change event when size feature negotiated; port0 only.
// - receive data returned on the receive queue owned by its port.
// - control message is id32, event16, value16, little-endian.
// - device messages only on control receive queue, driver ones on control transmit.
// - event codes 0..7 with fixed sender per code, except open (6) from either side.
// - resize message followed by cols16 and rows16; value unused.
// - open/close value 1 open, 0 closed, sent by either side.
// - name message followed by UTF-8 name with no terminating zero.
// - never add an existing port or one at or above the port limit.
// - remove only ports created by an earlier add.
module mcd_console_core #(
	parameter int MAX_PORTS = 4
) (
	input  wire logic        mclk,
	input  wire logic        sys_rst,
	input  wire logic [7:0]  paddr,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [31:0] pwdata,
	input  wire logic [3:0]  pstrb,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	output logic             urgent_char_valid,
	output logic      [7:0]  urgent_char_data,
	output logic             cfg_change,
	output logic             cmsg_valid,
	output logic      [7:0]  cmsg_queue,
	output logic      [63:0] cmsg_data,
	output logic      [31:0] cmsg_extra,
	output logic      [2:0]  cmsg_extra_len,
	input  wire logic        cmsg_ready,
	input  wire logic        cin_valid,
	input  wire logic [7:0]  cin_queue,
	input  wire logic [63:0] cin_data,
	output logic             cin_ready,
	input  wire logic        host_rx_valid,
	input  wire logic [7:0]  host_rx_port,
	input  wire logic [7:0]  host_rx_byte,
	output logic             host_rx_ready,
	output logic             drv_rx_valid,
	output logic      [7:0]  drv_rx_queue,
	output logic      [7:0]  drv_rx_byte,
	input  wire logic        drv_rx_ready,
	input  wire logic        drv_tx_valid,
	input  wire logic [7:0]  drv_tx_queue,
	input  wire logic [7:0]  drv_tx_byte,
	output logic             drv_tx_ready,
	output logic             host_tx_valid,
	output logic      [7:0]  host_tx_port,
	output logic      [7:0]  host_tx_byte,
	input  wire logic        host_tx_ready
);
	import mcd_pkg::*;

	localparam int PIX = (MAX_PORTS > 1) ? $clog2(MAX_PORTS) : 1;
	localparam logic [31:0] PORT_LIMIT = 32'(MAX_PORTS);

	logic [15:0]          cols_reg;
	logic [15:0]          rows_reg;
	logic [2:0]           feat_ack_reg;
	logic [1:0]           mode_reg;
	logic [31:0]          hport_reg;
	logic [31:0]          name_reg;
	logic                 drv_ready_reg;
	logic                 refused_reg;
	logic                 drv_fail_reg;
	logic [MAX_PORTS-1:0] exist_reg;
	logic [MAX_PORTS-1:0] pready_map_reg;
	logic [MAX_PORTS-1:0] gopen_reg;
	logic [31:0]          rd_data;
	logic                 rd_err;
	logic                 wr_go;
	logic                 swap;
	logic                 multi;

	// byte reversal within one field, for the guest-native legacy order
	function automatic logic [15:0] sw16(input logic [15:0] v, input logic en);
		sw16 = en ? {v[7:0], v[15:8]} : v;
	endfunction
	function automatic logic [31:0] sw32(input logic [31:0] v, input logic en);
		sw32 = en ? {v[7:0], v[15:8], v[23:16], v[31:24]} : v;
	endfunction

	// write strobe only in the completing access cycle
	assign wr_go = psel & penable & pready & pwrite & (pstrb == 4'hF);
	assign swap  = mode_reg[MCD_MODE_LEGACY] & mode_reg[MCD_MODE_GBE];
	assign multi = feat_ack_reg[MCD_F_MULTI];

	// read decode; reserved bits and bitmaps above MAX_PORTS read zero
	always_comb begin
		rd_data = 32'h0000_0000;
		rd_err  = 1'b0;
		unique case (paddr)
			MCD_ADDR_SIZE:     rd_data = {sw16(rows_reg, swap), sw16(cols_reg, swap)};
			MCD_ADDR_PLIMIT:   rd_data = sw32(PORT_LIMIT, swap);
			MCD_ADDR_URGENT:   rd_data = 32'h0000_0000;
			MCD_ADDR_FEAT_OFF: rd_data = {29'h0, MCD_FEAT_OFFERED};
			MCD_ADDR_FEAT_ACK: rd_data = {29'h0, feat_ack_reg};
			MCD_ADDR_MODE:     rd_data = {30'h0, mode_reg};
			MCD_ADDR_STATUS:   rd_data = {28'h0, drv_fail_reg, refused_reg, cmsg_valid,
				drv_ready_reg};
			MCD_ADDR_HPORT:    rd_data = hport_reg;
			MCD_ADDR_HCMD:     rd_data = 32'h0000_0000;
			MCD_ADDR_NEWSIZE:  rd_data = {rows_reg, cols_reg};
			MCD_ADDR_NAME:     rd_data = name_reg;
			MCD_ADDR_EXIST:    rd_data = 32'(exist_reg);
			MCD_ADDR_PREADY:   rd_data = 32'(pready_map_reg);
			MCD_ADDR_GOPEN:    rd_data = 32'(gopen_reg);
			default:           rd_err  = 1'b1;
		endcase
	end

	// no wait state: answer is raised in the first access cycle
	always_ff @(posedge mclk or posedge sys_rst) begin
		if (sys_rst) begin
			pready  <= 1'b0;
			pslverr <= 1'b0;
			prdata  <= 32'h0000_0000;
		end else begin
			pready  <= psel & ~penable;
			pslverr <= psel & ~penable & (rd_err | (pwrite & (pstrb != 4'hF)));
			prdata  <= (psel & ~penable & ~pwrite) ? rd_data : 32'h0000_0000;
		end
	end

	// software configuration registers
	always_ff @(posedge mclk or posedge sys_rst) begin
		if (sys_rst) begin
			feat_ack_reg <= MCD_FEAT_ACK_RST;
			mode_reg     <= MCD_MODE_RST;
			hport_reg    <= 32'h0000_0000;
			name_reg     <= 32'h0000_0000;
		end else if (wr_go) begin
			if (paddr == MCD_ADDR_FEAT_ACK)
				feat_ack_reg <= pwdata[2:0] & MCD_FEAT_OFFERED;
			if (paddr == MCD_ADDR_MODE)
				mode_reg <= pwdata[1:0];
			if (paddr == MCD_ADDR_HPORT)
				hport_reg <= pwdata;
			if (paddr == MCD_ADDR_NAME)
				name_reg <= pwdata;
		end
	end

	// emergency write is never gated by features or setup
	always_ff @(posedge mclk or posedge sys_rst) begin
		if (sys_rst) begin
			urgent_char_valid <= 1'b0;
			urgent_char_data  <= 8'h00;
		end else begin
			urgent_char_valid <= wr_go & (paddr == MCD_ADDR_URGENT);
			if (wr_go && paddr == MCD_ADDR_URGENT)
				urgent_char_data <= swap ? pwdata[31:24] : pwdata[7:0];
		end
	end

	// console size; the event only matters once size is negotiated
	always_ff @(posedge mclk or posedge sys_rst) begin
		if (sys_rst) begin
			cols_reg   <= MCD_COLS_RST;
			rows_reg   <= MCD_ROWS_RST;
			cfg_change <= 1'b0;
		end else begin
			cfg_change <= wr_go & (paddr == MCD_ADDR_NEWSIZE) & feat_ack_reg[MCD_F_SIZE];
			if (wr_go && paddr == MCD_ADDR_NEWSIZE) begin
				cols_reg <= pwdata[15:0];
				rows_reg <= pwdata[31:16];
			end
		end
	end

	// host command decode
	logic [15:0]    cmd_ev;
	logic [15:0]    cmd_val;
	logic [2:0]     cmd_nlen;
	logic           cmd_wr;
	logic           port_ok;
	logic [PIX-1:0] hidx;
	logic           cmd_legal;
	logic           cmd_send;

	assign cmd_ev   = {13'h0, pwdata[MCD_CMD_EV_LSB +: 3]};
	assign cmd_val  = pwdata[MCD_CMD_VAL_LSB +: 16];
	assign cmd_nlen = (pwdata[MCD_CMD_NLEN_LSB +: 3] > 3'h4) ? 3'h4 :
		pwdata[MCD_CMD_NLEN_LSB +: 3];
	assign cmd_wr   = wr_go & (paddr == MCD_ADDR_HCMD);
	assign port_ok  = hport_reg < PORT_LIMIT;
	assign hidx     = hport_reg[PIX-1:0];

	always_comb begin
		cmd_legal = 1'b0;
		unique case (cmd_ev)
			// no duplicate, no id at or above limit
			MCD_EV_PORT_ADD:  cmd_legal = port_ok && !exist_reg[hidx];
			MCD_EV_PORT_DEL:  cmd_legal = port_ok && exist_reg[hidx];
			MCD_EV_CONSOLE,
			MCD_EV_PORT_NAME,
			MCD_EV_PORT_OPEN: cmd_legal = port_ok && exist_reg[hidx] && pready_map_reg[hidx];
			MCD_EV_RESIZE:    cmd_legal = 1'b1;
			default:          cmd_legal = 1'b0;
		endcase
	end

	// nothing is sent before the driver announced itself
	assign cmd_send = cmd_wr & cmd_legal & multi & drv_ready_reg & ~cmsg_valid;

	// outgoing control message, single beat with optional trailer
	always_ff @(posedge mclk or posedge sys_rst) begin
		if (sys_rst) begin
			cmsg_valid     <= 1'b0;
			cmsg_queue     <= MCD_Q_CTRL_RX;
			cmsg_data      <= 64'h0;
			cmsg_extra     <= 32'h0;
			cmsg_extra_len <= 3'h0;
		end else if (cmd_send) begin
			cmsg_valid <= 1'b1;
			// device messages on control receive queue
			cmsg_queue <= MCD_Q_CTRL_RX;
			// id, event, value in byte order
			cmsg_data  <= {sw16((cmd_ev == MCD_EV_PORT_OPEN) ? cmd_val : 16'h0000, swap),
				sw16(cmd_ev, swap), sw32(hport_reg, swap)};
			if (cmd_ev == MCD_EV_RESIZE) begin
				cmsg_extra     <= {sw16(rows_reg, swap), sw16(cols_reg, swap)};
				cmsg_extra_len <= 3'h4;
			end else if (cmd_ev == MCD_EV_PORT_NAME) begin
				cmsg_extra     <= name_reg;
				cmsg_extra_len <= cmd_nlen;
			end else begin
				cmsg_extra     <= 32'h0;
				cmsg_extra_len <= 3'h0;
			end
		end else if (cmsg_valid && cmsg_ready) begin
			cmsg_valid <= 1'b0;
		end
	end

	// refused command flag; write-1 clears but a new refusal wins
	always_ff @(posedge mclk or posedge sys_rst) begin
		if (sys_rst)
			refused_reg <= 1'b0;
		else if (cmd_wr && !cmd_send)
			refused_reg <= 1'b1;
		else if (wr_go && paddr == MCD_ADDR_STATUS && pwdata[MCD_ST_REFUSED])
			refused_reg <= 1'b0;
	end

	// incoming driver messages, decoded after byte order fix
	logic [31:0]    in_id;
	logic [15:0]    in_ev;
	logic [15:0]    in_val;
	logic           in_go;
	logic           in_port_ok;
	logic [PIX-1:0] iidx;

	assign in_id      = sw32(cin_data[31:0], swap);
	assign in_ev      = sw16(cin_data[47:32], swap);
	assign in_val     = sw16(cin_data[63:48], swap);
	// driver messages only count on control transmit queue
	assign in_go      = cin_valid & cin_ready & (cin_queue == MCD_Q_CTRL_TX) & multi;
	assign in_port_ok = (in_id < PORT_LIMIT) && exist_reg[iidx];
	assign iidx       = in_id[PIX-1:0];

	// always ready: messages are consumed in one cycle
	always_ff @(posedge mclk or posedge sys_rst) begin
		if (sys_rst)
			cin_ready <= 1'b0;
		else
			cin_ready <= 1'b1;
	end

	// driver-ready tracking; value 1 success, id ignored
	always_ff @(posedge mclk or posedge sys_rst) begin
		if (sys_rst) begin
			drv_ready_reg <= 1'b0;
			drv_fail_reg  <= 1'b0;
		end else begin
			if (in_go && in_ev == MCD_EV_DRV_READY)
				drv_ready_reg <= (in_val == MCD_VAL_ONE);
			if (in_go && in_ev == MCD_EV_DRV_READY && in_val != MCD_VAL_ONE)
				drv_fail_reg <= 1'b1;
			else if (wr_go && paddr == MCD_ADDR_STATUS && pwdata[MCD_ST_DRV_FAIL])
				drv_fail_reg <= 1'b0;
		end
	end

	// port maps: created, driver-ready, driver-open
	always_ff @(posedge mclk or posedge sys_rst) begin
		if (sys_rst) begin
			exist_reg      <= '0;
			pready_map_reg <= '0;
			gopen_reg      <= '0;
		end else begin
			if (cmd_send && cmd_ev == MCD_EV_PORT_ADD)
				exist_reg[hidx] <= 1'b1;
			// remove clears all of the port's state
			if (cmd_send && cmd_ev == MCD_EV_PORT_DEL) begin
				exist_reg[hidx]      <= 1'b0;
				pready_map_reg[hidx] <= 1'b0;
				gopen_reg[hidx]      <= 1'b0;
			end else begin
				if (in_go && in_ev == MCD_EV_PORT_READY && in_port_ok)
					pready_map_reg[iidx] <= (in_val == MCD_VAL_ONE);
				if (in_go && in_ev == MCD_EV_PORT_OPEN && in_port_ok)
					gopen_reg[iidx] <= (in_val == MCD_VAL_ONE);
			end
		end
	end

	// port usable for data: port0 always, others once added under multiport
	function automatic logic usable(input logic [7:0] p, input logic m,
			input logic [MAX_PORTS-1:0] ex);
		usable = (p == 8'h00) || (m && (32'(p) < PORT_LIMIT) && ex[p[PIX-1:0]]);
	endfunction

	// receive path, one stage; unknown ports are drained and dropped
	logic rx_load;
	logic rx_valid_next;
	assign rx_load       = host_rx_valid & host_rx_ready;
	assign rx_valid_next = (rx_load & usable(host_rx_port, multi, exist_reg)) |
		(drv_rx_valid & ~drv_rx_ready);

	always_ff @(posedge mclk or posedge sys_rst) begin
		if (sys_rst) begin
			drv_rx_valid  <= 1'b0;
			drv_rx_queue  <= MCD_Q_P0_RX;
			drv_rx_byte   <= 8'h00;
			host_rx_ready <= 1'b0;
		end else begin
			drv_rx_valid  <= rx_valid_next;
			host_rx_ready <= ~rx_valid_next;
			if (rx_load) begin
				drv_rx_queue <= (host_rx_port == 8'h00) ? MCD_Q_P0_RX :
					8'(MCD_Q_P1_RX + {host_rx_port[6:0], 1'b0} - 8'h02);
				drv_rx_byte  <= host_rx_byte;
			end
		end
	end

	// transmit path: queue index back to port; even or control queues dropped
	logic       tx_load;
	logic       tx_qok;
	logic [7:0] tx_port;
	logic       tx_valid_next;
	assign tx_port = (drv_tx_queue == MCD_Q_P0_TX) ? 8'h00 :
		8'({1'b0, drv_tx_queue[7:1]} - 8'h01);
	assign tx_qok  = drv_tx_queue[0] && (drv_tx_queue != MCD_Q_CTRL_TX) &&
		usable(tx_port, multi, exist_reg);
	assign tx_load = drv_tx_valid & drv_tx_ready;
	assign tx_valid_next = (tx_load & tx_qok) | (host_tx_valid & ~host_tx_ready);

	always_ff @(posedge mclk or posedge sys_rst) begin
		if (sys_rst) begin
			host_tx_valid <= 1'b0;
			host_tx_port  <= 8'h00;
			host_tx_byte  <= 8'h00;
			drv_tx_ready  <= 1'b0;
		end else begin
			host_tx_valid <= tx_valid_next;
			drv_tx_ready  <= ~tx_valid_next;
			if (tx_load) begin
				host_tx_port <= tx_port;
				host_tx_byte <= drv_tx_byte;
			end
		end
	end

endmodule

//--- test/mcd_console_assertions.sv
`timescale 1ns/10ps
module mcd_console_assertions #(
	parameter int MAX_PORTS = 4
) (
	input wire logic        mclk,
	input wire logic        sys_rst,
	input wire logic [7:0]  paddr,
	input wire logic        psel,
	input wire logic        penable,
	input wire logic        pwrite,
	input wire logic [3:0]  pstrb,
	input wire logic [31:0] prdata,
	input wire logic        pready,
	input wire logic        pslverr,
	input wire logic        urgent_char_valid,
	input wire logic        cfg_change,
	input wire logic        cmsg_valid,
	input wire logic [7:0]  cmsg_queue,
	input wire logic [63:0] cmsg_data,
	input wire logic [2:0]  cmsg_extra_len,
	input wire logic        cmsg_ready,
	input wire logic        host_rx_valid,
	input wire logic [7:0]  host_rx_port,
	input wire logic [7:0]  host_rx_byte,
	input wire logic        host_rx_ready,
	input wire logic        drv_rx_valid,
	input wire logic [7:0]  drv_rx_queue,
	input wire logic [7:0]  drv_rx_byte,
	input wire logic        drv_rx_ready
);
	import mcd_pkg::*;
	logic [15:0] ev;
	logic [15:0] ev_sw;
	logic [31:0] id_sw;
	// legacy mode with guest big-endian swaps fields, so both byte orders are accepted
	assign ev = cmsg_data[47:32];
	assign ev_sw = {ev[7:0], ev[15:8]};
	assign id_sw = {cmsg_data[7:0], cmsg_data[15:8], cmsg_data[23:16], cmsg_data[31:24]};
	function automatic logic dev_ev(input logic [15:0] e);
		return e <= 16'h0007 && e != 16'h0000 && e != 16'h0003;
	endfunction
	default clocking cb @(posedge mclk); endclocking
	default disable iff (sys_rst);
	sequence apb_setup_s;
		psel && !penable;
	endsequence
	sequence urgent_wr_s;
		psel && penable && pready && pwrite && paddr == MCD_ADDR_URGENT && pstrb == 4'hF;
	endsequence
	apb_answer_a: assert property (apb_setup_s |=> pready)
		else $error("no answer after setup");
	ready_once_a: assert property (pready |=> !pready) else $error("pready longer than one cycle");
	err_timing_a: assert property (pslverr |-> pready) else $error("pslverr without pready");
	rdata_idle_a: assert property (!pready |-> prdata == 32'h0) else $error("read data outside answer");
	urgent_out_a: assert property (urgent_wr_s |-> ##[1:2] urgent_char_valid)
		else $error("urgent write gave no character");
	urgent_pulse_a: assert property (urgent_char_valid |=> !urgent_char_valid)
		else $error("urgent character pulse too long");
	change_pulse_a: assert property (cfg_change |=> !cfg_change)
		else $error("config change pulse too long");
	ctrl_queue_a: assert property (cmsg_valid |-> cmsg_queue == MCD_Q_CTRL_RX)
		else $error("device message on wrong queue");
	ctrl_hold_a: assert property (cmsg_valid && !cmsg_ready |=> cmsg_valid && $stable(cmsg_data))
		else $error("control message changed before accept");
	ctrl_event_a: assert property (cmsg_valid |-> dev_ev(ev) || dev_ev(ev_sw))
		else $error("device sent a driver event code");
	resize_len_a: assert property (
		cmsg_valid && (ev == MCD_EV_RESIZE || ev_sw == MCD_EV_RESIZE) |-> cmsg_extra_len == 3'h4)
		else $error("resize trailer length wrong");
	add_limit_a: assert property (
		cmsg_valid && (ev == MCD_EV_PORT_ADD || ev_sw == MCD_EV_PORT_ADD)
		|-> cmsg_data[31:0] < MAX_PORTS || id_sw < MAX_PORTS) else $error("port add above limit");
	rx_route_a: assert property (host_rx_valid && host_rx_ready && host_rx_port == 8'h00
		|=> drv_rx_valid && drv_rx_queue == MCD_Q_P0_RX && drv_rx_byte == $past(host_rx_byte))
		else $error("port 0 input misrouted");
	rx_hold_a: assert property (drv_rx_valid && !drv_rx_ready |=> drv_rx_valid && $stable(drv_rx_byte))
		else $error("receive data dropped while stalled");
endmodule
bind mcd_console_core mcd_console_assertions #(.MAX_PORTS(MAX_PORTS)) chk_u (.*);

//--- test/mcd_drv_model.sv
`timescale 1ns/10ps
module mcd_drv_model (
	input  wire logic mclk,
	input  wire logic sys_rst,
	input  wire logic cmsg_valid,
	input  wire logic drv_rx_valid,
	output logic      cmsg_ready,
	output logic      drv_rx_ready
);
	logic [2:0] pace_reg;
	// slow guest: buffers come back only now and then, so the device must hold its outputs
	always_ff @(posedge mclk or posedge sys_rst) begin
		if (sys_rst) begin
			pace_reg <= 3'h0;
		end else begin
			pace_reg <= pace_reg + 3'h1;
		end
	end
	assign cmsg_ready = cmsg_valid && pace_reg[1:0] == 2'h3;
	assign drv_rx_ready = drv_rx_valid && pace_reg == 3'h5;
endmodule

//--- test/multiport_console_device_test.sv
`timescale 1ns/10ps
module multiport_console_device_test;
	import mcd_pkg::*;
	logic        mclk, sys_rst, psel, penable, pwrite, cin_valid, host_rx_valid, drv_tx_valid;
	logic        host_tx_ready, cmsg_ready, drv_rx_ready, pready, pslverr, urgent_char_valid;
	logic        cfg_change, cmsg_valid, cin_ready, host_rx_ready, drv_rx_valid, drv_tx_ready;
	logic        host_tx_valid, drv_ok;
	logic [7:0]  paddr, cin_queue, host_rx_port, host_rx_byte, drv_tx_queue, drv_tx_byte;
	logic [7:0]  urgent_char_data, cmsg_queue, drv_rx_queue, drv_rx_byte, host_tx_port, host_tx_byte;
	logic [31:0] pwdata, prdata, cmsg_extra, sz, r, name_w;
	logic [63:0] cin_data, cmsg_data;
	logic [3:0]  pstrb;
	logic [2:0]  cmsg_extra_len;
	logic [98:0] q_exp[6][$];
	int          n_fail = 0;
	int          n_compared = 0;
	mcd_console_core #(.MAX_PORTS(4)) dut_u (.*);
	mcd_drv_model drv_u (.*);
	initial begin
		mclk = 1'b0;
		forever #5 mclk = ~mclk;
	end
	task give_verdict();
		if (n_fail == 0 && n_compared > 0) $display("No errors found");
		else $display("Errors were found");
		$finish;
	endtask
	task compare(input string what, input logic [98:0] e, input logic [98:0] g);
		n_compared++;
		if (g !== e) begin
			n_fail++;
			$display("[ERR] %s expected %h seen %h", what, e, g);
		end
	endtask
	// an unexpected result counts as a mismatch
	task got(input int k, input string what, input logic [98:0] g);
		if (q_exp[k].size() == 0) compare(what, 99'h0, ~g);
		else compare(what, q_exp[k].pop_front(), g);
	endtask
	// monitor: one note is taken per result that appears
	always @(posedge mclk) begin
		if (pready === 1'b1 && psel && penable && !pwrite)
			got(0, "read", {pslverr, prdata});
		if (cmsg_valid === 1'b1 && cmsg_ready === 1'b1) begin
			got(1, "message", {cmsg_data, cmsg_extra & ~(32'hFFFFFFFF << (8 * cmsg_extra_len)),
				cmsg_extra_len});
			compare("message queue", MCD_Q_CTRL_RX, cmsg_queue);
		end
		if (drv_rx_valid === 1'b1 && drv_rx_ready === 1'b1)
			got(2, "rx", {drv_rx_queue, drv_rx_byte});
		if (host_tx_valid === 1'b1 && host_tx_ready === 1'b1)
			got(3, "tx", {host_tx_port, host_tx_byte});
		if (urgent_char_valid === 1'b1)
			got(4, "urgent", urgent_char_data);
		if (cfg_change === 1'b1)
			got(5, "cfg change", 99'h1);
	end
	// host side stalls at random
	always @(posedge mclk) host_tx_ready <= 1'($urandom);
	task apb(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [32:0] e);
		@(posedge mclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		if (!w) q_exp[0].push_back(e);
		@(posedge mclk);
		penable <= 1'b1;
		// only the watchdog ends a wait for the answer
		do @(posedge mclk); while (pready !== 1'b1);
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task wr(input logic [7:0] a, input logic [31:0] d);
		apb(1'b1, a, d, 33'h0);
	endtask
	task rd(input logic [7:0] a, input logic [31:0] e);
		apb(1'b0, a, 32'h0, {1'b0, e});
	endtask
	task host_in(input logic [7:0] p, input logic [7:0] b);
		@(posedge mclk);
		host_rx_valid <= 1'b1;
		host_rx_port <= p;
		host_rx_byte <= b;
		do @(posedge mclk); while (host_rx_ready !== 1'b1);
		host_rx_valid <= 1'b0;
	endtask
	task drv_out(input logic [7:0] q, input logic [7:0] b);
		@(posedge mclk);
		drv_tx_valid <= 1'b1;
		drv_tx_queue <= q;
		drv_tx_byte <= b;
		do @(posedge mclk); while (drv_tx_ready !== 1'b1);
		drv_tx_valid <= 1'b0;
	endtask
	task cin_send(input logic [63:0] d);
		@(posedge mclk);
		cin_valid <= 1'b1;
		cin_queue <= MCD_Q_CTRL_TX;
		cin_data <= d;
		do @(posedge mclk); while (cin_ready !== 1'b1);
		cin_valid <= 1'b0;
	endtask
	// host command, then expected message or refusal in the status word
	task cmd(input logic [7:0] p, input logic [2:0] ev, input logic [2:0] len, input logic [15:0] v,
		input logic refd);
		wr(MCD_ADDR_HPORT, {24'h0, p});
		wr(MCD_ADDR_HCMD, {v, 9'h0, len, 1'b0, ev});
		if (!refd) q_exp[1].push_back({(ev == 3'h6) ? v : 16'h0, 13'h0, ev, 24'h0, p,
			(ev == 3'h5) ? sz : ((ev == 3'h7) ? name_w & ~(32'hFFFFFFFF << (8 * len)) : 32'h0),
			(ev == 3'h5) ? 3'h4 : ((ev == 3'h7) ? len : 3'h0)});
		repeat (2) @(posedge mclk);
		while (cmsg_valid === 1'b1) @(posedge mclk);
		rd(MCD_ADDR_STATUS, {29'h0, refd, 1'b0, drv_ok});
		if (refd) wr(MCD_ADDR_STATUS, 32'h4);
	endtask
	// a hang ends the run
	initial begin
		#200000;
		n_fail++;
		give_verdict();
	end
	initial begin
		sys_rst = 1'b1;
		drv_ok = 1'b0;
		{psel, penable, pwrite, cin_valid, host_rx_valid, drv_tx_valid} = '0;
		{paddr, pwdata, cin_queue, cin_data, host_rx_port, host_rx_byte, drv_tx_queue, drv_tx_byte} = '0;
		pstrb = 4'hF;
		void'($urandom(32'hd284));
		repeat (12) @(posedge mclk);
		sys_rst <= 1'b0;
		repeat (3) @(posedge mclk);
		rd(MCD_ADDR_SIZE, {MCD_ROWS_RST, MCD_COLS_RST});
		rd(MCD_ADDR_PLIMIT, 32'h4);
		rd(MCD_ADDR_FEAT_OFF, {29'h0, MCD_FEAT_OFFERED});
		rd(MCD_ADDR_URGENT, 32'h0);
		apb(1'b0, 8'h40, 32'h0, {1'b1, 32'h0});
		r = $urandom;
		q_exp[4].push_back(r[7:0]);
		wr(MCD_ADDR_URGENT, r);
		sz = $urandom;
		wr(MCD_ADDR_NEWSIZE, sz);
		q_exp[2].push_back({MCD_Q_P0_RX, r[7:0]});
		host_in(8'h00, r[7:0]);
		q_exp[3].push_back({8'h00, r[15:8]});
		drv_out(MCD_Q_P0_TX, r[15:8]);
		wr(MCD_ADDR_FEAT_ACK, 32'hFFFFFFFF);
		rd(MCD_ADDR_FEAT_ACK, 32'h7);
		sz = $urandom;
		q_exp[5].push_back(99'h1);
		wr(MCD_ADDR_NEWSIZE, sz);
		rd(MCD_ADDR_SIZE, sz);
		wr(MCD_ADDR_MODE, 32'h1);
		rd(MCD_ADDR_SIZE, sz);
		wr(MCD_ADDR_MODE, 32'h3);
		rd(MCD_ADDR_SIZE, {sz[23:16], sz[31:24], sz[7:0], sz[15:8]});
		q_exp[4].push_back(r[31:24]);
		wr(MCD_ADDR_URGENT, r);
		wr(MCD_ADDR_MODE, 32'h0);
		cmd(8'h01, 3'h1, 3'h0, 16'h0, 1'b1);
		cin_send({16'h0, MCD_EV_DRV_READY, 32'h0});
		rd(MCD_ADDR_STATUS, 32'h8);
		wr(MCD_ADDR_STATUS, 32'h8);
		cin_send({MCD_VAL_ONE, MCD_EV_DRV_READY, 32'h5});
		drv_ok = 1'b1;
		rd(MCD_ADDR_STATUS, 32'h1);
		cmd(8'h01, 3'h1, 3'h0, 16'h0, 1'b0);
		cmd(8'h01, 3'h1, 3'h0, 16'h0, 1'b1);
		cmd(8'h04, 3'h1, 3'h0, 16'h0, 1'b1);
		cmd(8'h02, 3'h2, 3'h0, 16'h0, 1'b1);
		cmd(8'h01, 3'h0, 3'h0, 16'h0, 1'b1);
		cmd(8'h01, 3'h3, 3'h0, 16'h0, 1'b1);
		cmd(8'h01, 3'h7, 3'h2, 16'h0, 1'b1);
		cin_send({MCD_VAL_ONE, MCD_EV_PORT_READY, 32'h1});
		cmd(8'h01, 3'h4, 3'h0, 16'h0, 1'b0);
		name_w = $urandom;
		wr(MCD_ADDR_NAME, name_w);
		// a partial-strobe write must leave the word alone
		pstrb <= 4'h3;
		wr(MCD_ADDR_NAME, ~name_w);
		pstrb <= 4'hF;
		rd(MCD_ADDR_NAME, name_w);
		cmd(8'h01, 3'h7, 3'h2, 16'h0, 1'b0);
		cmd(8'h01, 3'h6, 3'h0, 16'h1, 1'b0);
		cmd(8'h01, 3'h5, 3'h0, 16'h0, 1'b0);
		cin_send({MCD_VAL_ONE, MCD_EV_PORT_OPEN, 32'h1});
		rd(MCD_ADDR_GOPEN, 32'h2);
		rd(MCD_ADDR_EXIST, 32'h2);
		q_exp[2].push_back({MCD_Q_P1_RX, r[7:0]});
		host_in(8'h01, r[7:0]);
		host_in(8'h02, r[15:8]);
		q_exp[3].push_back({8'h01, r[23:16]});
		drv_out(8'h05, r[23:16]);
		cmd(8'h01, 3'h2, 3'h0, 16'h0, 1'b0);
		cmd(8'h01, 3'h2, 3'h0, 16'h0, 1'b1);
		repeat (20) @(posedge mclk);
		for (int k = 0; k < 6; k++) if (q_exp[k].size() != 0) n_fail++;
		give_verdict();
	end
endmodule
